// File: hdl/xid_pkg.sv
// package for the exchange instruction decoder: opcode constants, form codes, operand codes
// assumes a fetch unit that hands over one opcode byte per accepted valid/ready beat
package xid_pkg;
    localparam logic [7:0] OP_B_DISP = 8'h06;
    localparam logic [7:0] OP_B_IDX24 = 8'h0a;
    localparam logic [7:0] OP_B_BASEIDX = 8'h17;
    localparam logic [7:0] OP_W_REGREG = 8'h25;
    localparam logic [7:0] OP_W_ACC_SA2 = 8'h1b;
    localparam logic [7:0] OP_W_REG_MEM = 8'h39;
    localparam logic [7:0] OP_W_PTR = 8'h07;
    localparam logic [7:0] OP_PREFIX = 8'h3c;
    localparam logic [7:0] OP_W_SA = 8'h2a;
    localparam logic [7:0] SB_PTR_NEAR = 8'h25;
    localparam logic [7:0] SB_PTR_FAR = 8'h35;
    localparam logic [7:0] SB_ABS16 = 8'h45;
    localparam logic [7:0] SB_ABS24 = 8'h55;
    localparam logic [7:0] SB_SA2_SA2 = 8'h84;
    localparam logic [7:0] SB_SA2_SA1 = 8'h94;
    localparam logic [3:0] LOW_NIB_BYTE = 4'h4;
    localparam logic [1:0] REGMEM_TAG = 2'h1;
    localparam logic [2:0] REGMEM_MID = 3'h2;
    localparam logic [2:0] MAX_PTR_SEL = 3'h4;
    // form codes reported to the execute stage
    localparam logic [4:0] F_NONE = 5'h00;
    localparam logic [4:0] F_B_DISP = 5'h01;
    localparam logic [4:0] F_B_IDX24 = 5'h02;
    localparam logic [4:0] F_B_BASEIDX = 5'h03;
    localparam logic [4:0] F_W_REGREG = 5'h04;
    localparam logic [4:0] F_W_ACC_SA2 = 5'h05;
    localparam logic [4:0] F_W_REG_SA2 = 5'h06;
    localparam logic [4:0] F_W_REG_SA1 = 5'h07;
    localparam logic [4:0] F_W_REG_SFR = 5'h08;
    localparam logic [4:0] F_W_PTR_SA2 = 5'h09;
    localparam logic [4:0] F_W_PTR_SA1 = 5'h0a;
    localparam logic [4:0] F_W_FAR_SA2 = 5'h0b;
    localparam logic [4:0] F_W_FAR_SA1 = 5'h0c;
    localparam logic [4:0] F_W_ABS16 = 5'h0d;
    localparam logic [4:0] F_W_ABS24 = 5'h0e;
    localparam logic [4:0] F_W_SA2_SA2 = 5'h0f;
    localparam logic [4:0] F_W_SA2_SA1 = 5'h10;
    localparam logic OPSZ_BYTE = 1'b0;
    localparam logic OPSZ_WORD = 1'b1;
    localparam logic [2:0] LEN_2 = 3'h2;
    localparam logic [2:0] LEN_3 = 3'h3;
    localparam logic [2:0] LEN_4 = 3'h4;
    localparam logic [2:0] LEN_5 = 3'h5;
    localparam int unsigned MAX_BYTES = 5;
endpackage : xid_pkg

// File: hdl/xid_byte_slot.sv
// one captured instruction byte
// assumes load is a single-cycle strobe from the decoder sequencer
module xid_byte_slot (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic load,
    input wire logic [7:0] din,
    output logic [7:0] dout
);
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dout <= 8'h00;
        end else if (load) begin
            dout <= din;
        end
    end
endmodule : xid_byte_slot

// File: hdl/xid_decoder.sv
// exchange instruction decoder: collects opcode bytes, names form, operands and length
// assumes the fetch unit drives byte_valid/byte_data and holds them until byte_ready
module xid_decoder (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    output logic byte_ready,
    output logic dec_valid,
    output logic dec_undecoded,
    output logic [4:0] dec_form,
    output logic dec_opsize,
    output logic dec_swap,
    output logic [2:0] dec_len,
    output logic [2:0] dec_sel_a,
    output logic [2:0] dec_sel_b,
    output logic [23:0] dec_addr_a,
    output logic [7:0] dec_addr_b
);
    typedef enum logic [1:0] {XID_COLLECT, XID_REPORT} xid_state_t;
    xid_state_t state_reg;
    logic [2:0] count_reg;
    logic [7:0] b [xid_pkg::MAX_BYTES];
    logic [xid_pkg::MAX_BYTES-1:0] load;
    logic take;
    // combinational classification of the bytes gathered so far
    logic [4:0] form;
    logic [2:0] need;
    logic bad;
    logic [2:0] sel_a;
    logic [2:0] sel_b;
    logic [23:0] addr_a;
    logic [7:0] addr_b;
    logic [7:0] cur [xid_pkg::MAX_BYTES];

    assign take = byte_valid && byte_ready;

    genvar gi;
    generate
        for (gi = 0; gi < xid_pkg::MAX_BYTES; gi++) begin : g_slot
            assign load[gi] = take && (count_reg == 3'(gi));
            xid_byte_slot u_slot (
                .clk_sys(clk_sys),
                .reset(reset),
                .load(load[gi]),
                .din(byte_data),
                .dout(b[gi])
            );
            // newest byte is visible the cycle it is taken, so the decision needs no extra stage
            assign cur[gi] = load[gi] ? byte_data : b[gi];
        end
    endgenerate

    // need = total length once known, the byte count so far plus one while more bytes are required to tell
    always_comb begin
        form = xid_pkg::F_NONE;
        need = 3'h0;
        bad = 1'b0;
        sel_a = 3'h0;
        sel_b = 3'h0;
        addr_a = 24'h000000;
        addr_b = 8'h00;
        case (cur[0])
            xid_pkg::OP_B_DISP: begin
                if (cur[1][7] || cur[1][3:0] != xid_pkg::LOW_NIB_BYTE || cur[1][6:4] > xid_pkg::MAX_PTR_SEL) begin
                    bad = 1'b1;
                end
                form = xid_pkg::F_B_DISP;
                need = xid_pkg::LEN_3;
                sel_a = cur[1][6:4];
                addr_a = {16'h0000, cur[2]};
            end
            xid_pkg::OP_B_IDX24: begin
                if (cur[1][7:6] == 2'h0 && cur[1][3:0] == xid_pkg::LOW_NIB_BYTE) begin
                    form = xid_pkg::F_B_IDX24;
                    need = xid_pkg::LEN_5;
                    sel_a = {1'b0, cur[1][5:4]};
                    addr_a = {cur[4], cur[3], cur[2]};
                end else if (cur[1] == xid_pkg::SB_ABS16) begin
                    form = xid_pkg::F_W_ABS16;
                    need = xid_pkg::LEN_4;
                    addr_a = {8'h00, cur[3], cur[2]};
                end else if (cur[1] == xid_pkg::SB_ABS24) begin
                    form = xid_pkg::F_W_ABS24;
                    need = xid_pkg::LEN_5;
                    addr_a = {cur[2], cur[4], cur[3]};
                end else begin
                    bad = 1'b1;
                    need = xid_pkg::LEN_2;
                end
            end
            xid_pkg::OP_B_BASEIDX: begin
                bad = cur[1][7] || cur[1][3:0] != xid_pkg::LOW_NIB_BYTE;
                form = xid_pkg::F_B_BASEIDX;
                need = xid_pkg::LEN_2;
                sel_a = cur[1][6:4];
            end
            xid_pkg::OP_W_REGREG: begin
                bad = cur[1][4:3] != xid_pkg::REGMEM_TAG;
                form = xid_pkg::F_W_REGREG;
                need = xid_pkg::LEN_2;
                sel_a = cur[1][7:5];
                sel_b = cur[1][2:0];
            end
            xid_pkg::OP_W_ACC_SA2: begin
                form = xid_pkg::F_W_ACC_SA2;
                need = xid_pkg::LEN_2;
                addr_a = {16'h0000, cur[1]};
            end
            xid_pkg::OP_W_REG_MEM: begin
                need = xid_pkg::LEN_3;
                sel_a = cur[1][7:5];
                addr_a = {16'h0000, cur[2]};
                if (cur[1][4:2] != xid_pkg::REGMEM_MID) begin
                    bad = 1'b1;
                end
                case (cur[1][1:0])
                    2'h0: form = xid_pkg::F_W_REG_SA2;
                    2'h1: form = xid_pkg::F_W_REG_SA1;
                    2'h2: form = xid_pkg::F_W_REG_SFR;
                    default: bad = 1'b1;
                endcase
            end
            xid_pkg::OP_W_PTR: begin
                need = xid_pkg::LEN_3;
                addr_a = {16'h0000, cur[2]};
                if (cur[1] == xid_pkg::SB_PTR_NEAR) begin
                    form = xid_pkg::F_W_PTR_SA2;
                end else if (cur[1] == xid_pkg::SB_PTR_FAR) begin
                    form = xid_pkg::F_W_FAR_SA2;
                end else begin
                    bad = 1'b1;
                    need = xid_pkg::LEN_2;
                end
            end
            xid_pkg::OP_PREFIX: begin
                need = xid_pkg::LEN_4;
                addr_a = {16'h0000, cur[3]};
                if (cur[1] != xid_pkg::OP_W_PTR) begin
                    bad = 1'b1;
                    need = xid_pkg::LEN_2;
                end else if (cur[2] == xid_pkg::SB_PTR_NEAR) begin
                    form = xid_pkg::F_W_PTR_SA1;
                end else if (cur[2] == xid_pkg::SB_PTR_FAR) begin
                    form = xid_pkg::F_W_FAR_SA1;
                end else if (count_reg >= 3'h2) begin
                    // byte three is judged only once it is here; a stale slot would end the prefix form early
                    bad = 1'b1;
                    need = xid_pkg::LEN_3;
                end
            end
            xid_pkg::OP_W_SA: begin
                need = xid_pkg::LEN_4;
                addr_a = {16'h0000, cur[3]};
                addr_b = cur[2];
                if (cur[1] == xid_pkg::SB_SA2_SA2) begin
                    form = xid_pkg::F_W_SA2_SA2;
                end else if (cur[1] == xid_pkg::SB_SA2_SA1) begin
                    form = xid_pkg::F_W_SA2_SA1;
                end else begin
                    bad = 1'b1;
                    need = xid_pkg::LEN_2;
                end
            end
            default: begin
                bad = 1'b1;
                need = 3'h1;
            end
        endcase
        // length is not settled until the bytes that choose it have arrived
        if (cur[0] != xid_pkg::OP_B_DISP && cur[0] != xid_pkg::OP_B_BASEIDX
            && cur[0] != xid_pkg::OP_W_REGREG && count_reg == 3'h0 && need > 3'h1) begin
            need = xid_pkg::LEN_2;
        end
        if (cur[0] == xid_pkg::OP_PREFIX && count_reg == 3'h1 && !bad) begin
            need = xid_pkg::LEN_3;
        end
        if (bad) begin
            form = xid_pkg::F_NONE;
            sel_a = 3'h0;
            sel_b = 3'h0;
            addr_a = 24'h000000;
            addr_b = 8'h00;
        end
    end

    // sequencer: accept bytes until the form's length is reached, then report one cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg <= XID_COLLECT;
            count_reg <= 3'h0;
            byte_ready <= 1'b0;
        end else begin
            case (state_reg)
                XID_COLLECT: begin
                    byte_ready <= 1'b1;
                    if (take) begin
                        // a bad first/second byte stops early rather than guessing the length
                        if (count_reg + 3'h1 >= need || (bad && count_reg >= 3'h1) || need == 3'h1) begin
                            state_reg <= XID_REPORT;
                            count_reg <= 3'h0;
                            byte_ready <= 1'b0;
                        end else begin
                            count_reg <= count_reg + 3'h1;
                        end
                    end
                end
                XID_REPORT: begin
                    state_reg <= XID_COLLECT;
                    byte_ready <= 1'b1;
                end
                default: begin
                    state_reg <= XID_COLLECT;
                    count_reg <= 3'h0;
                    byte_ready <= 1'b0;
                end
            endcase
        end
    end

    // result registers, loaded as the last byte is taken
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dec_valid <= 1'b0;
            dec_undecoded <= 1'b0;
            dec_form <= xid_pkg::F_NONE;
            dec_opsize <= xid_pkg::OPSZ_BYTE;
            dec_swap <= 1'b0;
            dec_len <= 3'h0;
            dec_sel_a <= 3'h0;
            dec_sel_b <= 3'h0;
            dec_addr_a <= 24'h000000;
            dec_addr_b <= 8'h00;
        end else if (state_reg == XID_COLLECT && take
                     && (count_reg + 3'h1 >= need || (bad && count_reg >= 3'h1) || need == 3'h1)) begin
            dec_valid <= 1'b1;
            dec_undecoded <= bad;
            dec_form <= form;
            dec_len <= count_reg + 3'h1;
            // byte forms come from three first bytes only; all else here, undecoded included, is marked word size
            dec_opsize <= (form == xid_pkg::F_B_DISP || form == xid_pkg::F_B_IDX24
                           || form == xid_pkg::F_B_BASEIDX) ? xid_pkg::OPSZ_BYTE : xid_pkg::OPSZ_WORD;
            dec_swap <= !bad;
            dec_sel_a <= sel_a;
            dec_sel_b <= sel_b;
            dec_addr_a <= addr_a;
            dec_addr_b <= addr_b;
        end else begin
            dec_valid <= 1'b0;
        end
    end
endmodule : xid_decoder

// File: sim/xid_fetch_model.sv
// fetch unit model: queues opcode bytes and offers them one per valid/ready beat
// assumes bytes are pushed by the bench only after reset has been released
module xid_fetch_model (
    input wire logic clk_sys,
    input wire logic byte_ready,
    output logic byte_valid,
    output logic [7:0] byte_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] q[$];
    logic taken = 1'b0;
    initial begin
        byte_valid = 1'b0;
        byte_data = 8'h00;
    end
    task push(input logic [7:0] b);
        q.push_back(b);
    endtask : push
    // a byte is dropped only after the edge that took it, so it is held until accepted
    always @(posedge clk_sys) taken <= byte_valid && byte_ready;
    // bytes leave in push order; an idle line shows the inverse of the last value
    always @(negedge clk_sys) begin
        if (taken) begin
            void'(q.pop_front());
        end
        byte_valid <= q.size() > 0;
        byte_data <= (q.size() > 0) ? q[0] : ~byte_data;
    end
endmodule : xid_fetch_model

// File: sim/xid_chk.sv
// checker for the exchange instruction decoder, bound to its ports
// assumes the single clk_sys domain with synchronous reset
module xid_chk (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic byte_ready,
    input wire logic dec_valid,
    input wire logic dec_undecoded,
    input wire logic [4:0] dec_form,
    input wire logic dec_opsize,
    input wire logic dec_swap,
    input wire logic [2:0] dec_len
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt_reg;
    logic [7:0] first_reg;
    // counts bytes taken since the last report, so length is judged against the real traffic
    always_ff @(posedge clk_sys) begin
        if (reset || dec_valid) cnt_reg <= 3'h0;
        else if (byte_valid && byte_ready) cnt_reg <= cnt_reg + 3'h1;
    end
    always_ff @(posedge clk_sys) begin
        if (reset) first_reg <= 8'h00;
        else if (byte_valid && byte_ready && cnt_reg == 3'h0) first_reg <= byte_data;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_report;
        !byte_ready ##1 byte_ready;
    endsequence
    a_report_gap: assert property (dec_valid |-> s_report) else $error("ready gap wrong");
    a_valid_pulse: assert property (dec_valid |=> !dec_valid) else $error("valid not a pulse");
    a_len_count: assert property (dec_valid |-> dec_len == cnt_reg) else $error("length wrong");
    a_undec_form: assert property (dec_valid && dec_undecoded |-> dec_form == xid_pkg::F_NONE && !dec_swap)
        else $error("undecoded fields wrong");
    a_swap_set: assert property (dec_valid && !dec_undecoded |-> dec_swap) else $error("swap missing");
    a_first_unknown: assert property (dec_valid && cnt_reg == 3'h1 |-> dec_undecoded)
        else $error("one byte decoded");
    a_disp_form: assert property (dec_valid && !dec_undecoded && first_reg == xid_pkg::OP_B_DISP
        |-> dec_form == xid_pkg::F_B_DISP && dec_len == xid_pkg::LEN_3) else $error("disp form wrong");
    a_baseidx_len: assert property (dec_valid && !dec_undecoded && first_reg == xid_pkg::OP_B_BASEIDX
        |-> dec_len == xid_pkg::LEN_2 && dec_opsize == xid_pkg::OPSZ_BYTE) else $error("baseidx wrong");
    a_word_size: assert property (dec_valid && !dec_undecoded && dec_form > xid_pkg::F_B_BASEIDX
        |-> dec_opsize == xid_pkg::OPSZ_WORD) else $error("word size wrong");
endmodule : xid_chk
bind xid_decoder xid_chk u_chk (.clk_sys(clk_sys), .reset(reset), .byte_valid(byte_valid),
    .byte_data(byte_data), .byte_ready(byte_ready), .dec_valid(dec_valid), .dec_undecoded(dec_undecoded),
    .dec_form(dec_form), .dec_opsize(dec_opsize), .dec_swap(dec_swap), .dec_len(dec_len));

// File: sim/xid_decoder_tb.sv
// testbench for the exchange instruction decoder with a queued fetch model
// assumes 250 MHz clk_sys; fields other than dec_sel_b are left unchecked where a form does not define them
module xid_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic byte_valid, byte_ready, dec_valid, dec_undecoded, dec_opsize, dec_swap;
    logic [7:0] byte_data, dec_addr_b;
    logic [4:0] dec_form;
    logic [2:0] dec_len, dec_sel_a, dec_sel_b;
    logic [23:0] dec_addr_a;
    int err_count = 0;
    int cmp_count = 0;
    always #2 clk_sys = ~clk_sys;
    xid_decoder uut (.clk_sys(clk_sys), .reset(reset), .byte_valid(byte_valid), .byte_data(byte_data),
        .byte_ready(byte_ready), .dec_valid(dec_valid), .dec_undecoded(dec_undecoded), .dec_form(dec_form),
        .dec_opsize(dec_opsize), .dec_swap(dec_swap), .dec_len(dec_len), .dec_sel_a(dec_sel_a),
        .dec_sel_b(dec_sel_b), .dec_addr_a(dec_addr_a), .dec_addr_b(dec_addr_b));
    xid_fetch_model fetch (.clk_sys(clk_sys), .byte_ready(byte_ready), .byte_valid(byte_valid),
        .byte_data(byte_data));
    task results;
        if (err_count == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    task check(input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // m: bit0 check sel_a, bit1 addr_a, bit2 addr_b
    task run(input logic [39:0] b, input int n, input logic [4:0] f, input int sa,
        input int sb, input int aa, input int ab, input int m);
        int i;
        for (i = 0; i < n; i++) fetch.push(b[39 - 8 * i -: 8]);
        i = 0;
        while (dec_valid !== 1'b1 && i < 40) begin
            @(negedge clk_sys);
            i++;
        end
        if (i == 40) begin
            err_count++;
            results();
        end
        check(dec_len, 24'(n));
        check(dec_form, f);
        check(dec_undecoded, f == xid_pkg::F_NONE);
        if (f != xid_pkg::F_NONE) begin
            check(dec_swap, 1'b1);
            check(dec_opsize, f > xid_pkg::F_B_BASEIDX);
            check(dec_sel_b, 24'(sb));
            if (m[0]) check(dec_sel_a, 24'(sa));
            if (m[1]) check(dec_addr_a, 24'(aa));
            if (m[2]) check(dec_addr_b, 24'(ab));
        end
        @(negedge clk_sys);
    endtask : run
    task t_byte;
        int k;
        for (k = 0; k < 5; k++) begin
            run({8'h06, 1'b0, k[2:0], 4'h4, 24'h5a0000}, 3, 5'h01, k, 0, 24'h5a, 0, 3);
        end
        for (k = 0; k < 4; k++) begin
            run({8'h0a, 2'b00, k[1:0], 4'h4, 24'h112233}, 5, 5'h02, k, 0, 24'h332211, 0, 3);
        end
        for (k = 0; k < 8; k++) begin
            run({8'h17, 1'b0, k[2:0], 4'h4, 24'h0}, 2, 5'h03, k, 0, 0, 0, 1);
        end
        // a pointer field above four is refused as soon as byte two is seen, so no displacement follows
        run({8'h06, 8'h54, 24'h0}, 2, 5'h00, 0, 0, 0, 0, 0);
        run({8'h0a, 8'h66, 24'h0}, 2, 5'h00, 0, 0, 0, 0, 0);
    endtask : t_byte
    task t_word_reg;
        int k;
        run({8'h25, 8'hca, 24'h0}, 2, 5'h04, 3'h6, 3'h2, 0, 0, 1);
        run({8'h25, 8'hc2, 24'h0}, 2, 5'h00, 0, 0, 0, 0, 0);
        run({8'h1b, 8'h77, 24'h0}, 2, 5'h05, 0, 0, 24'h77, 0, 2);
        for (k = 0; k < 3; k++) begin
            run({8'h39, 6'h1a, k[1:0], 24'h990000}, 3, 5'(6 + k), 3, 0, 24'h99, 0, 3);
        end
        run({8'h39, 8'h6b, 24'h0}, 2, 5'h00, 0, 0, 0, 0, 0);
    endtask : t_word_reg
    task t_word_mem;
        run({8'h07, 8'h25, 8'hab, 16'h0}, 3, 5'h09, 0, 0, 24'hab, 0, 2);
        run({8'h3c, 8'h07, 8'h25, 8'hcd, 8'h0}, 4, 5'h0a, 0, 0, 24'hcd, 0, 2);
        run({8'h07, 8'h35, 8'h12, 16'h0}, 3, 5'h0b, 0, 0, 24'h12, 0, 2);
        run({8'h3c, 8'h07, 8'h35, 8'h34, 8'h0}, 4, 5'h0c, 0, 0, 24'h34, 0, 2);
        run({8'h0a, 8'h45, 8'h34, 8'h12, 8'h0}, 4, 5'h0d, 0, 0, 24'h1234, 0, 2);
        run({8'h0a, 8'h55, 8'h56, 8'h34, 8'h12}, 5, 5'h0e, 0, 0, 24'h561234, 0, 2);
        run({8'h2a, 8'h84, 8'h11, 8'h22, 8'h0}, 4, 5'h0f, 0, 0, 24'h22, 8'h11, 6);
        run({8'h2a, 8'h94, 8'h33, 8'h44, 8'h0}, 4, 5'h10, 0, 0, 24'h44, 8'h33, 6);
        run({8'hff, 32'h0}, 1, 5'h00, 0, 0, 0, 0, 0);
        run({8'h2a, 8'h85, 24'h0}, 2, 5'h00, 0, 0, 0, 0, 0);
    endtask : t_word_mem
    initial begin
        repeat (12) @(negedge clk_sys);
        reset = 1'b0;
        t_byte();
        t_word_reg();
        t_word_mem();
        results();
    end
endmodule : xid_decoder_tb
